/* File: pkg/sensor_regs_pkg.sv */
// constants and types shared by the sensor register bank
// Behaviour
// - writing 0x5a to 0x3a resets the chip
// - writing 0xe7 to 0x3b enters shutdown
// - 0x3e reads inverted silicon revision code
// - 0x3f reads inverted part identity code
// - reading 0x42 streams seven burst bytes
// - motion data cleared after third burst byte
// - burst may end anytime after X byte
package sensor_regs_pkg;

   // register addresses, seven bits after the direction bit
   localparam logic [6:0] ADDR_CHIP_RESET  = 7'h3A;
   localparam logic [6:0] ADDR_POWER_DOWN  = 7'h3B;
   localparam logic [6:0] ADDR_INV_REV     = 7'h3E;
   localparam logic [6:0] ADDR_INV_PART    = 7'h3F;
   localparam logic [6:0] ADDR_BURST       = 7'h42;

   // trigger values
   localparam logic [7:0] CHIP_RESET_KEY   = 8'h5A;
   localparam logic [7:0] POWER_DOWN_KEY   = 8'hE7;

   // value after reset, and the filler sent past the last burst byte
   localparam logic [7:0] TX_RESET         = 8'h00;
   localparam logic [7:0] BURST_RESET      = 8'h00;

   // burst sequencing
   localparam logic [2:0] BURST_LAST_IDX   = 3'h6;
   localparam logic [2:0] BURST_CLEAR_IDX  = 3'h2;

   // direction bit of the address byte, high means write
   localparam int         WRITE_BIT        = 7;

   // one motion sample as handed to the burst
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] delta_x;
      logic [7:0] delta_y;
      logic [7:0] surface_quality;
      logic [7:0] shutter_hi;
      logic [7:0] shutter_lo;
      logic [7:0] peak_pixel;
   } motion_sample_t;

   // transaction state, one-hot
   typedef enum logic [3:0] {
      ST_ADDR  = 4'b0001,
      ST_WDATA = 4'b0010,
      ST_READ  = 4'b0100,
      ST_BURST = 4'b1000
   } xfer_state_t;

endpackage : sensor_regs_pkg

/* File: logic/serial_link.sv */
// serial port shifter running on the link clock
`timescale 1ns/1ps
module serial_link (
   // serial pins
   input  wire logic       sclk,
   input  wire logic       ncs_n,
   input  wire logic       mosi,
   output logic            miso,
   output logic            miso_oe,
   // towards the register core
   input  wire logic [7:0] tx_byte,
   output logic      [7:0] rx_byte,
   output logic            rx_first,
   output logic            rx_toggle
);
   import sensor_regs_pkg::*;

   logic [2:0] bit_cnt;
   logic [2:0] next_bit_cnt;
   logic [6:0] rx_shift;
   logic [6:0] next_rx_shift;
   logic       first_flag;
   logic       next_first_flag;
   logic [7:0] next_rx_byte;
   logic       next_rx_first;
   logic       next_rx_toggle;
   logic [7:0] tx_shift;
   logic [7:0] next_tx_shift;

   ////////////////////////////////////////////////////////////////////////
   // receive side, sampled on the rising edge
   always_comb begin
      next_bit_cnt    = bit_cnt + 3'h1;
      next_rx_shift   = {rx_shift[5:0], mosi};
      next_first_flag = first_flag;
      next_rx_byte    = rx_byte;
      next_rx_first   = rx_first;
      next_rx_toggle  = rx_toggle;
      if (bit_cnt == 3'h7) begin
         next_rx_byte    = {rx_shift, mosi};
         next_rx_first   = first_flag;
         next_rx_toggle  = ~rx_toggle;   // one event per byte
         next_first_flag = 1'b0;
      end
   end

   // frame end clears the shifter, the clock stands still after it
   always_ff @(posedge sclk or posedge ncs_n) begin
      if (ncs_n) begin
         bit_cnt    <= 3'h0;
         rx_shift   <= 7'h00;
         first_flag <= 1'b1;
         rx_byte    <= 8'h00;
         rx_first   <= 1'b0;
         rx_toggle  <= 1'b0;
      end else begin
         bit_cnt    <= next_bit_cnt;
         rx_shift   <= next_rx_shift;
         first_flag <= next_first_flag;
         rx_byte    <= next_rx_byte;
         rx_first   <= next_rx_first;
         rx_toggle  <= next_rx_toggle;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit side, msb first, shifted on the falling edge
   always_comb begin
      next_tx_shift = {tx_shift[6:0], 1'b0};
      if (bit_cnt == 3'h0) begin
         next_tx_shift = tx_byte;       // word held still by the core
      end
   end

   always_ff @(negedge sclk or posedge ncs_n) begin
      if (ncs_n) begin
         tx_shift <= TX_RESET;
      end else begin
         tx_shift <= next_tx_shift;
      end
   end

   // pin drive only inside a frame
   assign miso    = tx_shift[7];
   assign miso_oe = ~ncs_n;

endmodule : serial_link

/* File: logic/sensor_regs.sv */
// register bank with reset, shutdown, id and burst readout
`timescale 1ns/1ps
module sensor_regs #(
   parameter logic [7:0] REV_CODE  = 8'h3C,   // arbitrary value
   parameter logic [7:0] PART_CODE = 8'h15    // arbitrary value
) (
   // system
   input  wire logic                           clk,
   input  wire logic                           sys_rst,
   // serial pins
   input  wire logic                           sclk,
   input  wire logic                           ncs_n,
   input  wire logic                           mosi,
   output logic                                miso,
   output logic                                miso_oe,
   // motion core
   input  wire sensor_regs_pkg::motion_sample_t sample_in,
   output logic                                motion_clear,
   // chip control
   output logic                                chip_reset,
   output logic                                shutdown
);
   import sensor_regs_pkg::*;

   logic [7:0]     link_rx;
   logic           link_first;
   logic           link_toggle;
   logic           ncs_m;
   logic           ncs_s;
   logic           tog_m;
   logic           tog_s;
   logic           tog_d;
   logic           byte_ev;
   logic           addr_ev;
   logic           data_ev;
   logic           is_write;

   xfer_state_t    state;
   xfer_state_t    next_state;
   logic [6:0]     addr;
   logic [6:0]     next_addr;
   logic [7:0]     tx_byte;
   logic [7:0]     next_tx_byte;
   logic [2:0]     burst_idx;
   logic [2:0]     next_burst_idx;
   motion_sample_t snap;
   motion_sample_t next_snap;
   logic           next_shutdown;
   logic           next_chip_reset;
   logic           next_motion_clear;

   ////////////////////////////////////////////////////////////////////////
   // link side shifter
   serial_link u_link (
      .sclk      (sclk),
      .ncs_n     (ncs_n),
      .mosi      (mosi),
      .miso      (miso),
      .miso_oe   (miso_oe),
      .tx_byte   (tx_byte),
      .rx_byte   (link_rx),
      .rx_first  (link_first),
      .rx_toggle (link_toggle)
   );

   ////////////////////////////////////////////////////////////////////////
   // crossings: chip select level and byte toggle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ncs_m <= 1'b1;
         ncs_s <= 1'b1;
         tog_m <= 1'b0;
         tog_s <= 1'b0;
         tog_d <= 1'b0;
      end else begin
         ncs_m <= ncs_n;
         ncs_s <= ncs_m;
         tog_m <= link_toggle;
         tog_s <= tog_m;
         tog_d <= tog_s;
      end
   end

   // byte events inside a frame only
   assign byte_ev  = (tog_s ^ tog_d) & ~ncs_s;
   // a plain read's data byte is not an address; the byte after it is
   assign addr_ev  = byte_ev & (link_first | (state == ST_ADDR));
   assign data_ev  = byte_ev & ~addr_ev;
   assign is_write = link_rx[WRITE_BIT];

   ////////////////////////////////////////////////////////////////////////
   // read value of an ordinary register
   function automatic logic [7:0] read_value(input logic [6:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == ADDR_INV_REV) begin
         v = ~REV_CODE;
      end else if (a == ADDR_INV_PART) begin
         v = ~PART_CODE;
      end
      return v;
   endfunction : read_value

   // byte of the burst at a given position
   function automatic logic [7:0] burst_byte(input motion_sample_t s,
                                             input logic [2:0] i);
      logic [7:0] v;
      v = BURST_RESET;
      case (i)
         3'h0: v = s.status;
         3'h1: v = s.delta_x;
         3'h2: v = s.delta_y;
         3'h3: v = s.surface_quality;
         3'h4: v = s.shutter_hi;
         3'h5: v = s.shutter_lo;
         3'h6: v = s.peak_pixel;
         default: v = BURST_RESET;
      endcase
      return v;
   endfunction : burst_byte

   ////////////////////////////////////////////////////////////////////////
   // transaction sequencer, next values
   always_comb begin
      next_state        = state;
      next_addr         = addr;
      next_tx_byte      = tx_byte;
      next_burst_idx    = burst_idx;
      next_snap         = snap;
      next_shutdown     = shutdown;
      next_chip_reset   = 1'b0;
      next_motion_clear = 1'b0;
      if (ncs_s) begin
         next_state = ST_ADDR;
      end else if (addr_ev) begin
         next_addr = link_rx[6:0];
         if (is_write) begin
            next_state = ST_WDATA;
         end else if (link_rx[6:0] == ADDR_BURST) begin
            next_state     = ST_BURST;
            next_snap      = sample_in;
            next_burst_idx = 3'h0;
            next_tx_byte   = sample_in.status;
         end else begin
            next_state   = ST_READ;
            next_tx_byte = read_value(link_rx[6:0]);
         end
      end else if (data_ev) begin
         case (state)
            ST_WDATA: begin
               next_state = ST_ADDR;
               if (addr == ADDR_CHIP_RESET &&
                   link_rx == CHIP_RESET_KEY) begin
                  next_chip_reset = 1'b1;
                  next_shutdown   = 1'b0;
                  next_tx_byte    = TX_RESET;
               end else if (addr == ADDR_POWER_DOWN &&
                            link_rx == POWER_DOWN_KEY) begin
                  next_shutdown = 1'b1;
               end
            end
            ST_BURST: begin
               if (burst_idx == BURST_CLEAR_IDX) begin
                  next_motion_clear = 1'b1;
               end
               if (burst_idx < BURST_LAST_IDX) begin
                  next_burst_idx = burst_idx + 3'h1;
                  next_tx_byte   = burst_byte(snap, burst_idx + 3'h1);
               end else begin
                  next_tx_byte   = BURST_RESET;
               end
            end
            default: begin
               next_state = ST_ADDR;
            end
         endcase
      end
   end

   // transaction sequencer, registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state        <= ST_ADDR;
         addr         <= 7'h00;
         tx_byte      <= TX_RESET;
         burst_idx    <= 3'h0;
         snap         <= '0;
         shutdown     <= 1'b0;
         chip_reset   <= 1'b0;
         motion_clear <= 1'b0;
      end else begin
         state        <= next_state;
         addr         <= next_addr;
         tx_byte      <= next_tx_byte;
         burst_idx    <= next_burst_idx;
         snap         <= next_snap;
         shutdown     <= next_shutdown;
         chip_reset   <= next_chip_reset;
         motion_clear <= next_motion_clear;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic rst_wr;
   logic pd_wr;
   assign rst_wr = data_ev & (state == ST_WDATA) &
                   (addr == ADDR_CHIP_RESET) & (link_rx == CHIP_RESET_KEY);
   assign pd_wr  = data_ev & (state == ST_WDATA) &
                   (addr == ADDR_POWER_DOWN) & (link_rx == POWER_DOWN_KEY);

   property p_chip_reset;
      @(posedge clk) disable iff (sys_rst)
      rst_wr |=> chip_reset && !shutdown ##1 !chip_reset;
   endproperty
   a_chip_reset: assert property (p_chip_reset)
      else $error("reset key write gave no chip reset");

   property p_power_down;
      @(posedge clk) disable iff (sys_rst)
      pd_wr && !rst_wr |=> shutdown;
   endproperty
   a_power_down: assert property (p_power_down)
      else $error("shutdown key write did not enter shutdown");

   property p_power_down_hold;
      @(posedge clk) disable iff (sys_rst)
      shutdown && !rst_wr |=> shutdown;
   endproperty
   a_power_down_hold: assert property (p_power_down_hold)
      else $error("shutdown left without reset write");

   property p_inv_rev;
      @(posedge clk) disable iff (sys_rst)
      addr_ev && !is_write && link_rx[6:0] == ADDR_INV_REV
      |=> tx_byte == ~REV_CODE && state == ST_READ;
   endproperty
   a_inv_rev: assert property (p_inv_rev)
      else $error("inverted revision read wrong");

   property p_inv_part;
      @(posedge clk) disable iff (sys_rst)
      addr_ev && !is_write && link_rx[6:0] == ADDR_INV_PART
      |=> tx_byte == ~PART_CODE;
   endproperty
   a_inv_part: assert property (p_inv_part)
      else $error("inverted part read wrong");

   property p_burst_start;
      @(posedge clk) disable iff (sys_rst)
      addr_ev && !is_write && link_rx[6:0] == ADDR_BURST
      |=> state == ST_BURST && burst_idx == 3'h0 &&
          tx_byte == $past(sample_in.status);
   endproperty
   a_burst_start: assert property (p_burst_start)
      else $error("burst did not start with status byte");

   property p_burst_clear;
      @(posedge clk) disable iff (sys_rst)
      data_ev && state == ST_BURST && burst_idx == BURST_CLEAR_IDX
      |=> motion_clear && burst_idx == 3'h3 ##1 !motion_clear;
   endproperty
   a_burst_clear: assert property (p_burst_clear)
      else $error("motion not cleared after third burst byte");

   property p_early_end;
      @(posedge clk) disable iff (sys_rst)
      state == ST_BURST && ncs_s |=> state == ST_ADDR && !motion_clear;
   endproperty
   a_early_end: assert property (p_early_end)
      else $error("burst end by chip select not accepted");

   property p_reserved;
      @(posedge clk) disable iff (sys_rst)
      addr_ev && !is_write && link_rx[6:0] != ADDR_INV_REV &&
      link_rx[6:0] != ADDR_INV_PART && link_rx[6:0] != ADDR_BURST
      |=> tx_byte == 8'h00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved read not zero");

   property p_reserved_wr;
      @(posedge clk) disable iff (sys_rst)
      data_ev && state == ST_WDATA && !rst_wr && !pd_wr
      |=> shutdown == $past(shutdown) && !chip_reset;
   endproperty
   a_reserved_wr: assert property (p_reserved_wr)
      else $error("reserved write had an effect");

endmodule : sensor_regs

/* File: test/host_master.sv */
// serial port master model standing for the host microcontroller
`timescale 1ns/1ps
module host_master (
   // serial pins
   output logic      sclk,
   output logic      ncs_n,
   output logic      mosi,
   input  wire logic miso
);
   // link clock stands high and frame is closed outside transfers
   initial begin
      sclk  = 1'b1;
      ncs_n = 1'b1;
      mosi  = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // one byte, msb first, 30 ns link clock, then a gap for the tx word
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sclk  = 1'b0;
         mosi  = tx[i];
         #15;
         sclk  = 1'b1;
         rx[i] = miso;
         #15;
      end
      mosi = ~tx[0]; // hold over, show a changed level
      #400;          // more than 8 system cycles before next fall
   endtask : xfer
   // open or close a frame; closing ends any burst early
   task automatic frame(input logic open_it);
      ncs_n = ~open_it;
      #300;
   endtask : frame
   // address byte plus one data byte inside one frame
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] junk;
      frame(1'b1);
      xfer({1'b1, a}, junk);
      xfer(d, junk);
      frame(1'b0);
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      logic [7:0] junk;
      frame(1'b1);
      xfer({1'b0, a}, junk);
      xfer(8'h00, d);
      frame(1'b0);
   endtask : rd
   // chip reset write issued after shutdown before normal use
   task automatic wake();
      wr(7'h3A, 8'h5A);
   endtask : wake
endmodule : host_master

/* File: test/sensor_regs_test.sv */
// self-checking bench for the sensor register bank
`timescale 1ns/1ps
module sensor_regs_test;
   import sensor_regs_pkg::*;
   localparam logic [7:0] REV  = 8'h5C; // arbitrary value
   localparam logic [7:0] PART = 8'h91; // arbitrary value
   // expected readings, held at byte width so the inversion is not widened
   localparam logic [7:0] EXP_REV  = ~REV;
   localparam logic [7:0] EXP_PART = ~PART;
   logic           clk;
   logic           sys_rst;
   logic           sclk;
   logic           ncs_n;
   logic           mosi;
   logic           miso;
   logic           miso_oe;
   logic           motion_clear;
   logic           chip_reset;
   logic           shutdown;
   motion_sample_t sample_in;
   motion_sample_t snap;
   logic [7:0]     rx;
   logic [7:0]     junk;
   int             err_count;
   int             tests_run;
   int             n_reset;
   int             n_clear;
   ////////////////////////////////////////////////////////////////////////
   sensor_regs #(.REV_CODE(REV), .PART_CODE(PART)) uut (
      .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .ncs_n(ncs_n),
      .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
      .sample_in(sample_in), .motion_clear(motion_clear),
      .chip_reset(chip_reset), .shutdown(shutdown));
   // released data line floats to its pull-up level
   host_master host (.sclk(sclk), .ncs_n(ncs_n), .mosi(mosi),
                     .miso(miso_oe ? miso : 1'b1));
   ////////////////////////////////////////////////////////////////////////
   // 25 MHz system clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // count cycles in which the pulse outputs stand high
   always @(posedge clk) begin
      if (chip_reset === 1'b1) n_reset++;
      if (motion_clear === 1'b1) n_clear++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : tally_and_finish
   // watchdog well beyond the expected run of some 36 us
   initial begin
      #300000;
      err_count++;
      tally_and_finish();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst   = 1'b1;
      sample_in = '0;
      repeat (16) @(posedge clk);
      sys_rst   <= 1'b0;
      sample_in <= {8'h81, 8'h12, 8'hF3, 8'h44, 8'h05, 8'h6A, 8'h7F};
      repeat (6) @(posedge clk);
      check(shutdown, 1'b0);
      // identity reads and a reserved read
      host.rd(ADDR_INV_REV, rx);
      check(rx, EXP_REV);
      host.rd(ADDR_INV_PART, rx);
      check(rx, EXP_PART);
      host.rd(7'h30, rx);
      check(rx, 8'h00);
      // two plain reads in one frame, a write-coded dummy byte between
      host.frame(1'b1);
      host.xfer({1'b0, ADDR_INV_REV}, junk);
      host.xfer({1'b1, ADDR_CHIP_RESET}, rx);
      check(rx, EXP_REV);
      host.xfer({1'b0, ADDR_INV_PART}, junk);
      host.xfer(8'h00, rx);
      check(rx, EXP_PART);
      host.frame(1'b0);
      check(n_reset, 0);
      $display("test identity done");
      // ignored writes: reserved address, wrong key values
      host.wr(7'h3C, CHIP_RESET_KEY);
      host.wr(ADDR_CHIP_RESET, 8'h5B);
      host.wr(ADDR_POWER_DOWN, 8'hE6);
      check(n_reset, 0);
      check(shutdown, 1'b0);
      $display("test ignored writes done");
      // full burst with a sample change after the address byte
      snap = sample_in;
      n_clear = 0;
      host.frame(1'b1);
      host.xfer({1'b0, ADDR_BURST}, junk);
      @(posedge clk);
      sample_in <= ~snap;
      for (int i = 0; i < 8; i++) begin
         host.xfer(8'h00, rx);
         check(ncs_n === 1'b0 && miso_oe === 1'b1, 1'b1);
         if (i < 7) check(rx, snap[55 - 8 * i -: 8]);
         else check(rx, 8'h00);
         if (i == 1) check(n_clear, 0);
         if (i == 2) check(n_clear, 1);
      end
      host.frame(1'b0);
      check(n_clear, 1);
      $display("test full burst done");
      // burst ended after the X byte, then a fresh address phase
      snap = sample_in;
      n_clear = 0;
      host.frame(1'b1);
      host.xfer({1'b0, ADDR_BURST}, junk);
      host.xfer(8'h00, rx);
      check(rx, snap[55:48]);
      host.xfer(8'h00, rx);
      check(rx, snap[47:40]);
      host.frame(1'b0);
      check(n_clear, 0);
      check(miso_oe, 1'b0);
      host.rd(ADDR_INV_REV, rx);
      check(rx, EXP_REV);
      $display("test early end done");
      // shutdown, ignored attempts, then chip reset write
      host.wr(ADDR_POWER_DOWN, POWER_DOWN_KEY);
      check(shutdown, 1'b1);
      host.wr(ADDR_CHIP_RESET, 8'hA5);
      host.wr(ADDR_POWER_DOWN, 8'h00);
      check(shutdown, 1'b1);
      check(n_reset, 0);
      host.wake();
      check(n_reset, 1);
      check(shutdown, 1'b0);
      host.rd(ADDR_INV_PART, rx);
      check(rx, EXP_PART);
      $display("test shutdown and reset done");
      tally_and_finish();
   end
endmodule : sensor_regs_test
